// ===== link_tap_formatter.sv
// Link output formatter: places buffered pixels on three link channels.
// Assumes state writes on ref_clk and pixels from a FIFO on link_clk.
//
// How it works
// - Format byte selects pixel-to-port distribution
// - Code 01: one 8-bit pixel, port A
// - Code 02 default: 10-bit, A plus B[1:0]
// - Code 03: 12-bit, A plus B[3:0]
// - Code 04: 16-bit, low A, high B
// - Two-tap 8-bit: even A, odd B
// - Two-tap 10-bit: even A/B[1:0], odd C/B[5:4]
// - Two-tap 12-bit: even A/B[3:0], odd C/B[7:4]
// - Code 0A: four 8-bit taps over two channels
// - Four-tap 10-bit split across ch1 and ch2
// - Four-tap 12-bit split across ch1 and ch2
// - Four-tap 16-bit spans all three channels
// - Code 12: eight 8-bit taps in order
// - Codes 13 and 14 select the raw view; only 13 drives raw bits, 14 all zeros
// - Eight-tap 10-bit raw layout, first channel
// - Eight-tap 10-bit raw layout, second channel
// - Eight-tap 10-bit raw layout, third channel
// - Format byte lives at state offset 60
// - No data-valid; line-valid waits for buffer
`timescale 1ns/1ps
`include "link_format_defines.svh"

module link_tap_formatter (
  input  wire logic                         ref_clk,        // Control clock, 20 MHz
  input  wire logic                         sys_rst,        // Async reset, active high
  input  wire link_format_pkg::state_write_t state_wr,      // State memory byte write
  output logic [7:0]                        format_select,  // Format byte read-back
  input  wire logic                         link_clk,       // Link output clock
  input  wire link_format_pkg::pixel_beat_t pix_data,       // Pixels of the next beat
  input  wire logic                         pix_valid,      // Beat present
  input  wire logic                         pix_last,       // Beat ends the line
  output logic                              pix_ready,      // Beat taken this edge
  input  wire logic                         line_buffered,  // Whole line buffered
  input  wire logic                         frame_active,   // Frame in progress
  output link_format_pkg::port_group_t      link_ports,     // Port view
  output link_format_pkg::raw_group_t       link_raw,       // Raw transmitter view
  output logic                              raw_sel,        // Raw view in use
  output logic                              line_valid,     // Line-valid, all channels
  output logic                              frame_valid     // Frame-valid
);

  // Taps per beat for a format code; zero for unknown codes, which never start a line
  function automatic logic [3:0] taps_of(input logic [7:0] m);
    if (m >= `FMT_1TAP_8 && m <= `FMT_1TAP_16) return 4'h1;
    else if (m >= `FMT_2TAP_8 && m <= `FMT_2TAP_12) return 4'h2;
    else if (m >= `FMT_4TAP_8 && m <= `FMT_4TAP_16) return 4'h4;
    else if (m == `FMT_8TAP_8 || m == `FMT_8TAP_10) return 4'h8;
    else if (m == `FMT_10TAP_8) return 4'hA;
    else return 4'h0;
  endfunction

  // Port view of one beat
  function automatic link_format_pkg::port_group_t map_ports(
    input logic [7:0] m, input link_format_pkg::pixel_beat_t p);
    link_format_pkg::port_group_t g;
    g = '0;
    case (m)
      `FMT_1TAP_8:  g.first_link_channel.port_a = p[0][7:0];
      `FMT_1TAP_10:
      begin
        g.first_link_channel.port_a      = p[0][7:0];
        g.first_link_channel.port_b[1:0] = p[0][9:8];
      end
      `FMT_1TAP_12:
      begin
        g.first_link_channel.port_a      = p[0][7:0];
        g.first_link_channel.port_b[3:0] = p[0][11:8];
      end
      `FMT_1TAP_16:
      begin
        g.first_link_channel.port_a = p[0][7:0];
        g.first_link_channel.port_b = p[0][15:8];
      end
      `FMT_2TAP_8:
      begin
        g.first_link_channel.port_a = p[0][7:0];
        g.first_link_channel.port_b = p[1][7:0];
      end
      `FMT_2TAP_10, `FMT_4TAP_10:
      begin
        g.first_link_channel.port_a      = p[0][7:0];
        g.first_link_channel.port_b[1:0] = p[0][9:8];
        g.first_link_channel.port_c      = p[1][7:0];
        g.first_link_channel.port_b[5:4] = p[1][9:8];
        if (m == `FMT_4TAP_10)
        begin
          g.second_link_channel.port_b      = p[2][7:0];
          g.second_link_channel.port_c[1:0] = p[2][9:8];
          g.second_link_channel.port_a      = p[3][7:0];
          g.second_link_channel.port_c[5:4] = p[3][9:8];
        end
      end
      `FMT_2TAP_12, `FMT_4TAP_12:
      begin
        g.first_link_channel.port_a      = p[0][7:0];
        g.first_link_channel.port_b[3:0] = p[0][11:8];
        g.first_link_channel.port_c      = p[1][7:0];
        g.first_link_channel.port_b[7:4] = p[1][11:8];
        if (m == `FMT_4TAP_12)
        begin
          g.second_link_channel.port_b      = p[2][7:0];
          g.second_link_channel.port_c[3:0] = p[2][11:8];
          g.second_link_channel.port_a      = p[3][7:0];
          g.second_link_channel.port_c[7:4] = p[3][11:8];
        end
      end
      `FMT_4TAP_8:
      begin
        g.first_link_channel.port_a  = p[0][7:0];
        g.first_link_channel.port_b  = p[1][7:0];
        g.first_link_channel.port_c  = p[2][7:0];
        g.second_link_channel.port_a = p[3][7:0];
      end
      `FMT_4TAP_16:
      begin
        g.first_link_channel.port_a  = p[0][7:0];
        g.first_link_channel.port_b  = p[0][15:8];
        g.first_link_channel.port_c  = p[1][7:0];
        g.second_link_channel.port_a = p[1][15:8];
        g.second_link_channel.port_b = p[2][7:0];
        g.second_link_channel.port_c = p[2][15:8];
        g.third_link_channel.port_a  = p[3][7:0];
        g.third_link_channel.port_b  = p[3][15:8];
      end
      `FMT_8TAP_8:
      begin
        g.first_link_channel.port_a  = p[0][7:0];
        g.first_link_channel.port_b  = p[1][7:0];
        g.first_link_channel.port_c  = p[2][7:0];
        g.second_link_channel.port_a = p[3][7:0];
        g.second_link_channel.port_b = p[4][7:0];
        g.second_link_channel.port_c = p[5][7:0];
        g.third_link_channel.port_a  = p[6][7:0];
        g.third_link_channel.port_b  = p[7][7:0];
      end
      // Raw-bit codes and codes without video leave every port at zero
      default: g = '0;
    endcase
    return g;
  endfunction

  // Raw view of one eight-tap 10-bit beat, flags included
  function automatic link_format_pkg::raw_group_t map_raw(
    input link_format_pkg::pixel_beat_t p, input logic fv);
    link_format_pkg::raw_group_t r;
    r = '0;
    r.first_link_channel = {p[2][5:4], fv, 1'b1, p[2][3:0], p[1][9:0], p[0][9:0]};
    r.second_link_channel = {1'b1, p[5][2:0], p[4][9:0], p[3][9:0], p[2][9:6]};
    r.third_link_channel = {1'b1, p[7][9:0], p[6][9:0], p[5][9:3]};
    return r;
  endfunction

  // Control domain: format byte and its change toggle
  logic [7:0] format_select_q;  // Format byte
  logic       fmt_toggle_q;     // Flips on every format write
  wire        fmt_hit = state_wr.wr_en && (state_wr.addr == `FMT_SELECT_OFFSET);

  // Format byte write from host or stored configuration
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      format_select_q <= `FMT_SELECT_RESET;
      fmt_toggle_q    <= 1'b0;
    end
    else if (fmt_hit)
    begin
      format_select_q <= state_wr.data;
      fmt_toggle_q    <= ~fmt_toggle_q;
    end
  end
  assign format_select = format_select_q;

  // Link domain reset: asserted at once, released on link_clk
  logic [1:0] link_rst_q;  // Reset release stages
  wire        link_rst = link_rst_q[1];
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
      link_rst_q <= 2'b11;
    else
      link_rst_q <= {link_rst_q[0], 1'b0};
  end

  // Toggle crossing; the byte is stable for many link edges around it
  logic       tog_s1_q;     // First stage, read only by the second
  logic       tog_s2_q;     // Second stage
  logic       tog_s3_q;     // Edge reference
  logic [7:0] mode_new_q;   // Latest format seen on the link side
  logic [7:0] mode_use_q;   // Format applied to lines
  wire        tog_edge = tog_s2_q ^ tog_s3_q;
  always_ff @(posedge link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      tog_s1_q   <= 1'b0;
      tog_s2_q   <= 1'b0;
      tog_s3_q   <= 1'b0;
      mode_new_q <= `FMT_SELECT_RESET;
    end
    else
    begin
      tog_s1_q <= fmt_toggle_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      if (tog_edge)
        mode_new_q <= format_select_q;
    end
  end

  // Line sequencer
  link_format_pkg::out_state_t state_q;  // Current state
  link_format_pkg::out_state_t state_d;  // Next state
  wire beat = (state_q == link_format_pkg::ST_LINE) && pix_valid;
  wire has_taps = (taps_of(mode_new_q) != 4'h0);
  assign pix_ready = (state_q == link_format_pkg::ST_LINE);

  // Next state: a line starts only once it is wholly buffered
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      link_format_pkg::ST_IDLE:
        if (pix_valid && has_taps)
          state_d = link_format_pkg::ST_FILL;
      link_format_pkg::ST_FILL:
        if (line_buffered)
          state_d = link_format_pkg::ST_LINE;
      link_format_pkg::ST_LINE:
        if (beat && pix_last)
          state_d = link_format_pkg::ST_IDLE;
      default: state_d = link_format_pkg::ST_IDLE;
    endcase
  end

  // State and format in use; format changes only between lines
  always_ff @(posedge link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      state_q    <= link_format_pkg::ST_IDLE;
      mode_use_q <= `FMT_SELECT_RESET;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == link_format_pkg::ST_IDLE)
        mode_use_q <= mode_new_q;
    end
  end

  // Beat outputs; port and raw bits are zero outside a beat, raw_sel and frame_valid keep following
  wire raw_mode = (mode_use_q == `FMT_8TAP_10) || (mode_use_q == `FMT_10TAP_8);
  wire link_format_pkg::port_group_t ports_d =
    (beat && !raw_mode) ? map_ports(mode_use_q, pix_data) : '0;
  wire link_format_pkg::raw_group_t raw_d =
    (beat && mode_use_q == `FMT_8TAP_10) ? map_raw(pix_data, frame_active) : '0;
  logic [7:0] out_mode_q;  // Format of the beat on the outputs
  always_ff @(posedge link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      link_ports  <= '0;
      link_raw    <= '0;
      raw_sel     <= 1'b0;
      line_valid  <= 1'b0;
      frame_valid <= 1'b0;
      out_mode_q  <= `FMT_SELECT_RESET;
    end
    else
    begin
      link_ports  <= ports_d;
      link_raw    <= raw_d;
      raw_sel     <= raw_mode;
      line_valid  <= beat;
      frame_valid <= frame_active;
      out_mode_q  <= mode_use_q;
    end
  end

  // Checks in the control domain
  a_fmt_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fmt_hit |=> format_select_q == $past(state_wr.data))
    else $error("format byte not taken from offset 60");
  a_fmt_other: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_wr.wr_en && !fmt_hit |=> $stable(format_select_q))
    else $error("format byte changed by another offset");

  // Checks in the link domain
  sequence s_last_beat;
    beat && pix_last;
  endsequence
  sequence s_line_closed;
    !line_valid ##0 state_q == link_format_pkg::ST_IDLE;
  endsequence
  a_line_ends: assert property (@(posedge link_clk) disable iff (link_rst)
    s_last_beat |=> ##1 s_line_closed)
    else $error("line-valid did not end after last beat");
  a_lval_buffered: assert property (@(posedge link_clk) disable iff (link_rst)
    $rose(line_valid) |-> $past(line_buffered, 2))
    else $error("line started before it was buffered");
  a_fill_holds: assert property (@(posedge link_clk) disable iff (link_rst)
    state_q == link_format_pkg::ST_FILL && !line_buffered |=> !pix_ready ##1 !line_valid)
    else $error("beat taken while line not buffered");
  a_one_tap8: assert property (@(posedge link_clk) disable iff (link_rst)
    line_valid && out_mode_q == `FMT_1TAP_8 |->
      link_ports.first_link_channel.port_a == $past(pix_data[0][7:0])
      && link_ports.first_link_channel.port_b == 8'h00)
    else $error("one-tap 8-bit placement wrong");
  a_one_tap10: assert property (@(posedge link_clk) disable iff (link_rst)
    line_valid && out_mode_q == `FMT_1TAP_10 |->
      link_ports.first_link_channel.port_b == {6'h00, $past(pix_data[0][9:8])})
    else $error("one-tap 10-bit upper bits wrong");
  a_four_tap8: assert property (@(posedge link_clk) disable iff (link_rst)
    line_valid && out_mode_q == `FMT_4TAP_8 |->
      link_ports.second_link_channel.port_a == $past(pix_data[3][7:0]))
    else $error("four-tap 8-bit pixel 3 wrong");
  a_eight_tap8: assert property (@(posedge link_clk) disable iff (link_rst)
    line_valid && out_mode_q == `FMT_8TAP_8 |->
      link_ports.third_link_channel.port_b == $past(pix_data[7][7:0]))
    else $error("eight-tap 8-bit pixel 7 wrong");
  a_raw_flags: assert property (@(posedge link_clk) disable iff (link_rst)
    line_valid && out_mode_q == `FMT_8TAP_10 |->
      link_raw.first_link_channel[`TX_LVAL_CH1]
      && link_raw.second_link_channel[`TX_LVAL_CH23]
      && link_raw.third_link_channel[`TX_LVAL_CH23]
      && link_ports == '0)
    else $error("raw mode line-valid bits wrong");
  a_mode_held: assert property (@(posedge link_clk) disable iff (link_rst)
    state_q != link_format_pkg::ST_IDLE |=> $stable(mode_use_q))
    else $error("format changed in the middle of a line");
  a_four_tap16: assert property (@(posedge link_clk) disable iff (link_rst)
    line_valid && out_mode_q == `FMT_4TAP_16 |->
      link_ports.third_link_channel == {8'h00, $past(pix_data[3])})
    else $error("four-tap 16-bit pixel 3 wrong");
  a_raw_second: assert property (@(posedge link_clk) disable iff (link_rst)
    line_valid && out_mode_q == `FMT_8TAP_10 |->
      link_raw.second_link_channel[13:4] == $past(pix_data[3][9:0]))
    else $error("eight-tap 10-bit pixel D wrong");
  a_idle_zero: assert property (@(posedge link_clk) disable iff (link_rst)
    !line_valid |-> link_ports == '0 && link_raw == '0)
    else $error("port bits driven outside a beat");

endmodule

// ===== link_format_defines.svh
// Constants of the link output formatter: state-memory offset, mode codes,
// and reset value and raw flag bit positions. Assumes inclusion by bare name.
`ifndef LINK_FORMAT_DEFINES_SVH
`define LINK_FORMAT_DEFINES_SVH

// Byte offset of the output-format byte in the camera state memory
`define FMT_SELECT_OFFSET 9'h03C
// Format byte after reset: one tap, 10 bits
`define FMT_SELECT_RESET  8'h02

// Output-format codes
`define FMT_1TAP_8        8'h01
`define FMT_1TAP_10       8'h02
`define FMT_1TAP_12       8'h03
`define FMT_1TAP_16       8'h04
`define FMT_2TAP_8        8'h05
`define FMT_2TAP_10       8'h06
`define FMT_2TAP_12       8'h07
`define FMT_4TAP_8        8'h0A
`define FMT_4TAP_10       8'h0B
`define FMT_4TAP_12       8'h0C
`define FMT_4TAP_16       8'h0D
`define FMT_8TAP_8        8'h12
`define FMT_8TAP_10       8'h13
`define FMT_10TAP_8       8'h14

// Raw transmitter bit positions for the line and frame flags
`define TX_LVAL_CH1       24
`define TX_FVAL_CH1       25
`define TX_LVAL_CH23      27

`endif

// ===== link_format_pkg.sv
// Types shared by the link output formatter.
// Assumes link_format_defines.svh holds the numeric constants.
package link_format_pkg;

  // Eight pixels of one output beat, lane 0 is the lowest-numbered pixel
  typedef logic [7:0][15:0] pixel_beat_t;

  // Three 8-bit ports of one link channel
  typedef struct packed {
    logic [7:0] port_c;
    logic [7:0] port_b;
    logic [7:0] port_a;
  } port_set_t;

  // Port view of all three channels
  typedef struct packed {
    port_set_t third_link_channel;
    port_set_t second_link_channel;
    port_set_t first_link_channel;
  } port_group_t;

  // Raw transmitter view of all three channels
  typedef struct packed {
    logic [27:0] third_link_channel;
    logic [27:0] second_link_channel;
    logic [27:0] first_link_channel;
  } raw_group_t;

  // Byte write into the camera state memory
  typedef struct packed {
    logic       wr_en;
    logic [8:0] addr;
    logic [7:0] data;
  } state_write_t;

  // Output line sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FILL = 3'b010,
    ST_LINE = 3'b100
  } out_state_t;

endpackage

// ===== framegrabber_model.sv
// Framegrabber model: samples all three link channels on one edge.
// Assumes formatter outputs are registered on link_clk.
`timescale 1ns/1ps

module framegrabber_model (
  input wire logic                         link_clk,    // Link output clock
  input wire logic                         sys_rst,     // Reset, active high
  input wire link_format_pkg::port_group_t link_ports,  // Port view
  input wire link_format_pkg::raw_group_t  link_raw,    // Raw view
  input wire logic                         line_valid   // Line flag
);
  logic [155:0] beats[$];       // Captured beats, raw above ports
  int           idle_dirty = 0; // Edges with data outside a line

  // Capture every channel together at mid-period, where outputs have settled;
  // outside a line nothing may show
  always @(negedge link_clk)
  begin
    if (!sys_rst && line_valid)
      beats.push_back({link_raw, link_ports});
    else if (!sys_rst && {link_raw, link_ports} !== '0)
      idle_dirty++;
  end
endmodule

// ===== link_tap_formatter_tb.sv
// Testbench of the link output formatter: format writes and pixel lines.
// Assumes the framegrabber model file is compiled before this one.
`timescale 1ns/1ps

module link_tap_formatter_tb;
  logic                          ref_clk = 1'b0;  // Control clock
  logic                          link_clk;        // Link clock
  logic                          sys_rst = 1'b1;  // Reset
  link_format_pkg::state_write_t state_wr = '0;   // State write
  link_format_pkg::pixel_beat_t  pix_data = '0;   // Beat pixels
  logic                          pix_valid = 1'b0;
  logic                          pix_last = 1'b0;
  logic                          line_buffered = 1'b0;
  logic                          frame_active = 1'b0;
  logic [7:0]                    format_select;
  logic                          pix_ready;
  link_format_pkg::port_group_t  link_ports;
  link_format_pkg::raw_group_t   link_raw;
  logic                          raw_sel;
  logic                          line_valid;
  logic                          frame_valid;
  int                            errors = 0;      // Mismatches
  int                            n_tests = 0;     // Comparisons
  logic [7:0]                    modes[14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h12, 8'h13, 8'h14};

  // 20 MHz control clock
  always #25 ref_clk = ~ref_clk;

  // 12 ns link clock, phase offset from the control clock
  initial
  begin
    link_clk = 1'b0;
    #3.3;
    forever #6 link_clk = ~link_clk;
  end

  link_tap_formatter DUT (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .state_wr      (state_wr),
    .format_select (format_select),
    .link_clk      (link_clk),
    .pix_data      (pix_data),
    .pix_valid     (pix_valid),
    .pix_last      (pix_last),
    .pix_ready     (pix_ready),
    .line_buffered (line_buffered),
    .frame_active  (frame_active),
    .link_ports    (link_ports),
    .link_raw      (link_raw),
    .raw_sel       (raw_sel),
    .line_valid    (line_valid),
    .frame_valid   (frame_valid)
  );

  framegrabber_model fg (
    .link_clk   (link_clk),
    .sys_rst    (sys_rst),
    .link_ports (link_ports),
    .link_raw   (link_raw),
    .line_valid (line_valid)
  );

  // Compare and count
  task automatic chk(input logic [155:0] seen, input logic [155:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts, verdict, end of run
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Pixel pattern of beat k, distinct in every lane
  function automatic link_format_pkg::pixel_beat_t beat(input int k);
    link_format_pkg::pixel_beat_t b;
    for (int i = 0; i < 8; i++)
      b[i] = 16'(16'h9E37 * (k * 8 + i + 1));
    return b;
  endfunction

  // Expected {raw, ports} of one beat in format m
  function automatic logic [155:0] exp_beat(input logic [7:0] m,
                                            input link_format_pkg::pixel_beat_t p);
    logic [8:0][7:0] y;
    logic [83:0]     r;
    logic            t10;
    y = '0;
    r = '0;
    t10 = (m == 8'h06 || m == 8'h0B);
    case (m)
      8'h01, 8'h02, 8'h03, 8'h04:
      begin
        y[0] = p[0][7:0];
        y[1] = (m == 8'h04) ? p[0][15:8] : (m == 8'h03) ? {4'h0, p[0][11:8]} :
               (m == 8'h02) ? {6'h00, p[0][9:8]} : 8'h00;
      end
      8'h05: y[1:0] = {p[1][7:0], p[0][7:0]};
      8'h06, 8'h07, 8'h0B, 8'h0C:
      begin
        y[0] = p[0][7:0];
        y[2] = p[1][7:0];
        y[3] = p[3][7:0];
        y[4] = p[2][7:0];
        y[1] = t10 ? {2'h0, p[1][9:8], 2'h0, p[0][9:8]} : {p[1][11:8], p[0][11:8]};
        y[5] = t10 ? {2'h0, p[3][9:8], 2'h0, p[2][9:8]} : {p[3][11:8], p[2][11:8]};
        if (m < 8'h0A)
          y[5:3] = '0;
      end
      8'h0A, 8'h12:
      begin
        for (int i = 0; i < 8; i++)
          y[i] = p[i][7:0];
        if (m == 8'h0A)
          y[7:4] = '0;
      end
      8'h0D: y[7:0] = {p[3], p[2], p[1], p[0]};
      8'h13: r = {1'b1, p[7][9:0], p[6][9:0], p[5][9:3],
                  1'b1, p[5][2:0], p[4][9:0], p[3][9:0], p[2][9:6],
                  p[2][5:4], 1'b1, 1'b1, p[2][3:0], p[1][9:0], p[0][9:0]};
      default: r = '0;
    endcase
    return {r, y};
  endfunction

  // One state byte write, then time for the link side to apply it
  task automatic wr_state(input logic [8:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    state_wr = '{wr_en: 1'b1, addr: a, data: d};
    @(negedge ref_clk);
    state_wr = '0;
    repeat (10) @(negedge ref_clk);
  endtask

  // One line of nb beats; line_buffered comes late on purpose
  task automatic send_line(input int nb);
    int w;
    @(negedge link_clk);
    frame_active = 1'b1;
    pix_valid = 1'b1;
    repeat (4) @(negedge link_clk);
    chk(pix_ready, 1'b0);
    chk(line_valid, 1'b0);
    line_buffered = 1'b1;
    for (int k = 0; k < nb; k++)
    begin
      pix_data = beat(k);
      pix_last = (k == nb - 1);
      w = 0;
      while (pix_ready !== 1'b1 && w < 20)
      begin
        @(negedge link_clk);
        w++;
      end
      @(negedge link_clk);
    end
    pix_valid = 1'b0;
    pix_last = 1'b0;
    line_buffered = 1'b0;
    repeat (4) @(negedge link_clk);
  endtask

  // Watchdog: the run needs about 14 us
  initial
  begin
    #200000;
    errors++;
    final_report();
  end

  // Main sequence
  initial
  begin
    logic [155:0] e;  // Expected beat, raw above ports
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(format_select, 8'h02);
    chk({link_raw, link_ports}, '0);
    chk(frame_valid, 1'b0);
    wr_state(9'h03D, 8'h55);
    chk(format_select, 8'h02);
    $display("test reset and offset done");
    // Every format, three back-to-back beats each
    foreach (modes[j])
    begin
      wr_state(9'h03C, modes[j]);
      chk(format_select, modes[j]);
      chk(raw_sel, modes[j] == 8'h13 || modes[j] == 8'h14);
      fg.beats.delete();
      send_line(3);
      chk(fg.beats.size(), 3);
      for (int k = 0; k < 3 && k < fg.beats.size(); k++)
      begin
        e = exp_beat(modes[j], beat(k));
        chk(fg.beats[k][23:0], e[23:0]);
        chk(fg.beats[k][71:24], e[71:24]);
        chk(fg.beats[k][155:72], e[155:72]);
      end
      chk(frame_valid, 1'b1);
      $display("test format %h done", modes[j]);
    end
    // Reset in mid-run: link side falls back to the one-tap 10-bit default
    @(negedge ref_clk);
    sys_rst = 1'b1;
    frame_active = 1'b0;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(format_select, 8'h02);
    chk(raw_sel, 1'b0);
    chk(frame_valid, 1'b0);
    fg.beats.delete();
    send_line(3);
    chk(fg.beats.size(), 3);
    for (int k = 0; k < 3 && k < fg.beats.size(); k++)
    begin
      e = exp_beat(8'h02, beat(k));
      chk(fg.beats[k], e);
    end
    $display("test mid-run reset done");
    // Unknown code never starts a line
    wr_state(9'h03C, 8'hFE);
    chk(format_select, 8'hFE);
    fg.beats.delete();
    @(negedge link_clk);
    pix_valid = 1'b1;
    line_buffered = 1'b1;
    repeat (8) @(negedge link_clk);
    chk(pix_ready, 1'b0);
    pix_valid = 1'b0;
    line_buffered = 1'b0;
    repeat (4) @(negedge link_clk);
    chk(fg.beats.size(), 0);
    chk(fg.idle_dirty, 0);
    $display("test unknown code done");
    final_report();
  end
endmodule
